// >>> verif/mtpc_src.sv
`timescale 1ns/1ns
// Far-side interrupt sources: each request level is latched and held until lowered
module mtpc_src #(
    parameter int EXT_SRC = 4
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [EXT_SRC+1:0] req_set,
    input wire logic [EXT_SRC+1:0] req_clr,
    output logic soft_req,
    output logic timer_req,
    output logic [EXT_SRC-1:0] ext_req
);
    logic [EXT_SRC+1:0] lvl_r; // Held request levels
    logic [EXT_SRC+1:0] lvl_nxt;
    // Raise on set, drop only when the handler services it
    always_comb begin
        lvl_nxt = (lvl_r | req_set) & ~req_clr;
    end
    // Level storage, cleared with the core
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lvl_r <= '0;
        end else begin
            lvl_r <= lvl_nxt;
        end
    end
    assign soft_req = lvl_r[0];
    assign timer_req = lvl_r[1];
    assign ext_req = lvl_r[EXT_SRC+1:2];
endmodule // mtpc_src

// >>> verif/mtpc_trap_asserts.sv
`timescale 1ns/1ns
// Port-level checks on trap pending and cause bookkeeping
module mtpc_trap_asserts
    import mtpc_pkg::*;
#(
    parameter int EXT_SRC = 4
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic mach_soft_req,
    input wire logic mach_timer_req,
    input wire logic [EXT_SRC-1:0] mach_ext_req,
    input wire logic glob_ie,
    input wire logic [PEND_W-1:0] int_enable,
    input wire logic int_pending,
    input wire logic [CODE_W-1:0] int_code,
    input wire logic int_take,
    input wire logic exc_valid,
    input wire logic [CODE_W-1:0] exc_code,
    input wire logic ecall_valid,
    input wire logic [1:0] priv_mode,
    input wire logic exc_reject,
    input wire logic trap_loaded,
    input wire logic pend_we,
    input wire logic [XLEN-1:0] pend_wdata,
    input wire logic [XLEN-1:0] pend_rdata,
    input wire logic cause_we,
    input wire logic [XLEN-1:0] cause_wdata,
    input wire logic [XLEN-1:0] cause_rdata
);
    // Single clock domain
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Plain exception carrying a reserved code
    wire logic exc_rsv = exc_valid && !ecall_valid &&
        (exc_code == 10'h00a || exc_code == 10'h00e || exc_code >= 10'h010);
    wire logic exc_ok = exc_valid && !ecall_valid && !exc_rsv;
    property p_sw_write;
        pend_we |=> (pend_rdata & PEND_SW_MASK) == ($past(pend_wdata) & PEND_SW_MASK);
    endproperty
    a_sw_write: assert property (p_sw_write)
        else $error("sup bits miss write");
    property p_sw_hold;
        !pend_we |=> $stable(pend_rdata & PEND_SW_MASK);
    endproperty
    a_sw_hold: assert property (p_sw_hold) else $error("sup bits moved");
    property p_rsv_pend;
        (pend_rdata & ~64'h0000_0000_0000_0aaa) == 64'h0;
    endproperty
    a_rsv_pend: assert property (p_rsv_pend) else $error("unused pending bit set");
    property p_soft_up;
        mach_soft_req [*5] |-> pend_rdata[POS_MACH_SOFT];
    endproperty
    a_soft_up: assert property (p_soft_up) else $error("soft pending missing");
    property p_timer_up;
        mach_timer_req [*5] |-> pend_rdata[POS_MACH_TIMER];
    endproperty
    a_timer_up: assert property (p_timer_up) else $error("timer pending missing");
    property p_ext_up;
        (|mach_ext_req) [*5] |-> pend_rdata[POS_MACH_EXT];
    endproperty
    a_ext_up: assert property (p_ext_up) else $error("ext pending missing");
    property p_ext_down;
        !(|mach_ext_req) [*5] |-> !pend_rdata[POS_MACH_EXT];
    endproperty
    a_ext_down: assert property (p_ext_down) else $error("ext pending stuck");
    property p_int_take;
        int_take && int_pending && !exc_valid && !ecall_valid
            |=> trap_loaded && cause_rdata == {1'b1, 53'h0, $past(int_code)};
    endproperty
    a_int_take: assert property (p_int_take)
        else $error("interrupt cause wrong");
    property p_int_code;
        int_pending |-> int_code inside {10'h001, 10'h003, 10'h005, 10'h007, 10'h009, 10'h00b};
    endproperty
    a_int_code: assert property (p_int_code) else $error("interrupt code illegal");
    property p_int_gate;
        int_pending |-> $past(glob_ie);
    endproperty
    a_int_gate: assert property (p_int_gate) else $error("offer without enable");
    property p_exc;
        exc_ok |=> trap_loaded && cause_rdata == {54'h0, $past(exc_code)};
    endproperty
    a_exc: assert property (p_exc) else $error("exception cause wrong");
    property p_exc_rsv;
        exc_rsv |=> exc_reject && !trap_loaded && $stable(cause_rdata);
    endproperty
    a_exc_rsv: assert property (p_exc_rsv) else $error("reserved code recorded");
    property p_ecall;
        ecall_valid && priv_mode != 2'h2
            |=> trap_loaded && cause_rdata == {54'h0, 10'h008 + {8'h0, $past(priv_mode)}};
    endproperty
    a_ecall: assert property (p_ecall) else $error("ecall cause wrong");
    property p_cause_rsv;
        cause_rdata[62:10] == 53'h0;
    endproperty
    a_cause_rsv: assert property (p_cause_rsv) else $error("cause reserved bits set");
    // Main scenarios reached
    c_int: cover property (int_take && int_pending);
    c_ecall: cover property (ecall_valid);
    c_reject: cover property (exc_reject);
endmodule // mtpc_trap_asserts
bind mtpc_trap mtpc_trap_asserts #(.EXT_SRC(EXT_SRC)) chk_u (.clk(clk), .rstn(rstn),
    .mach_soft_req(mach_soft_req), .mach_timer_req(mach_timer_req),
    .mach_ext_req(mach_ext_req), .glob_ie(glob_ie), .int_enable(int_enable),
    .int_pending(int_pending), .int_code(int_code), .int_take(int_take),
    .exc_valid(exc_valid), .exc_code(exc_code), .ecall_valid(ecall_valid),
    .priv_mode(priv_mode), .exc_reject(exc_reject), .trap_loaded(trap_loaded),
    .pend_we(pend_we), .pend_wdata(pend_wdata), .pend_rdata(pend_rdata),
    .cause_we(cause_we), .cause_wdata(cause_wdata), .cause_rdata(cause_rdata));

// >>> verif/mtpc_trap_test.sv
`timescale 1ns/1ns
// Self-checking bench for trap pending and cause bookkeeping
module mtpc_trap_test;
    import mtpc_pkg::*;
    localparam int EXT_SRC = 4;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [EXT_SRC+1:0] req_set = '0; // Partner raise pulses
    logic [EXT_SRC+1:0] req_clr = '0; // Partner service pulses
    logic soft_req, timer_req;
    logic [EXT_SRC-1:0] ext_req;
    logic glob_ie = 1'b0, int_take = 1'b0, exc_valid = 1'b0, ecall_valid = 1'b0;
    logic pend_we = 1'b0, int_pending, exc_reject, trap_loaded;
    logic cause_we = 1'b0; // Software write strobe for the cause register
    logic [XLEN-1:0] cause_wdata = '0;
    logic [PEND_W-1:0] int_enable = '0;
    logic [CODE_W-1:0] exc_code = '0, int_code;
    logic [1:0] priv_mode = '0;
    logic [XLEN-1:0] pend_wdata = '0, pend_rdata, cause_rdata, rnd;
    logic [XLEN-1:0] exp_cause = '0; // Cause value the bench expects to stand
    logic [XLEN:0] exp_q[$]; // Notes of {reject, cause} per trap result
    int errors = 0, compares = 0, src, pos;

    mtpc_src #(.EXT_SRC(EXT_SRC)) src_u (.clk(clk), .rstn(rstn), .req_set(req_set),
        .req_clr(req_clr), .soft_req(soft_req), .timer_req(timer_req), .ext_req(ext_req));
    mtpc_trap #(.EXT_SRC(EXT_SRC)) dut_u (.clk(clk), .rstn(rstn),
        .mach_soft_req(soft_req), .mach_timer_req(timer_req), .mach_ext_req(ext_req),
        .glob_ie(glob_ie), .int_enable(int_enable), .int_pending(int_pending),
        .int_code(int_code), .int_take(int_take), .exc_valid(exc_valid),
        .exc_code(exc_code), .ecall_valid(ecall_valid), .priv_mode(priv_mode),
        .exc_reject(exc_reject), .trap_loaded(trap_loaded), .pend_we(pend_we),
        .pend_wdata(pend_wdata), .pend_rdata(pend_rdata), .cause_we(cause_we),
        .cause_wdata(cause_wdata), .cause_rdata(cause_rdata));

    // Free-running core clock
    initial forever #10 clk = ~clk;

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Compare and count
    task automatic check(input string what, input logic [XLEN:0] exp, input logic [XLEN:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Full-word write to the pending register, held one edge
    task automatic pend_write(input logic [XLEN-1:0] d);
        pend_we = 1'b1;
        pend_wdata = d;
        tick(1);
        pend_we = 1'b0;
        tick(1);
    endtask
    // Full-word write to the cause register, held one edge
    task automatic cause_write(input logic [XLEN-1:0] d);
        cause_we = 1'b1;
        cause_wdata = d;
        tick(1);
        cause_we = 1'b0;
        tick(1);
    endtask
    // Take the offered interrupt, noting the cause it must leave
    task automatic take(input logic [CODE_W-1:0] code);
        check("int_pending", 65'h1, int_pending);
        check("int_code", code, int_code);
        exp_cause = {1'b1, 53'h0, code};
        exp_q.push_back({1'b0, exp_cause});
        int_take = 1'b1;
        tick(1);
        int_take = 1'b0;
        tick(1);
    endtask
    // One exception or environment call pulse
    task automatic trap(input logic ec, input logic [9:0] code, input logic [1:0] pm,
        input logic rej);
        logic [9:0] ex;
        ex = !ec ? code : (pm == 2'h2 ? 10'h002 : 10'h008 + {8'h0, pm});
        if (!rej) begin
            exp_cause = {54'h0, ex};
        end
        exp_q.push_back({rej, exp_cause});
        exc_valid = !ec;
        ecall_valid = ec;
        exc_code = code;
        priv_mode = pm;
        tick(1);
        exc_valid = 1'b0;
        ecall_valid = 1'b0;
        tick(1);
    endtask
    // Verdict and end of run
    task automatic summarize();
        $display("comparisons %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Result watcher: every trap pulse consumes the oldest note
    always @(negedge clk) begin
        if (trap_loaded === 1'b1 || exc_reject === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("trap_note", 65'h1, 65'h0);
            end else begin
                check("trap_result", exp_q.pop_front(), {exc_reject, cause_rdata});
            end
        end
    end

    // Watchdog on a hung sequence
    initial begin
        #(20 * 3000);
        errors++;
        $display("mismatch watchdog expected done seen timeout");
        summarize();
    end

    initial begin
        void'($urandom(16));
        tick(5);
        rstn = 1'b1;
        check("pend_reset", 0, pend_rdata);
        check("cause_reset", 0, cause_rdata);
        pend_write(64'hffff_ffff_ffff_ffff);
        check("pend_ones", 65'h222, pend_rdata);
        repeat (4) begin
            rnd = {$urandom, $urandom};
            pend_write(rnd);
            check("pend_random", rnd & PEND_SW_MASK, pend_rdata);
        end
        pend_write(64'h0);
        int_enable = 12'hfff;
        glob_ie = 1'b1;
        // Machine sources one by one, external picked at random
        for (int i = 0; i < 3; i++) begin
            src = (i == 2) ? 2 + $urandom_range(EXT_SRC - 1) : i;
            pos = (i == 0) ? 3 : (i == 1) ? 7 : 11;
            req_set[src] = 1'b1;
            tick(1);
            req_set = '0;
            tick(6);
            check("pend_mach", 65'h1 << pos, pend_rdata);
            pend_write(64'h0);
            check("pend_mach_ro", 65'h1 << pos, pend_rdata);
            take(pos[9:0]);
            req_clr[src] = 1'b1;
            tick(1);
            req_clr = '0;
            tick(6);
        end
        // Supervisor bits set by software alone
        for (int k = 1; k < 10; k += 4) begin
            int_enable = 12'h001 << k;
            pend_write(64'h1 << k);
            check("pend_sup", 65'h1 << k, pend_rdata);
            take(k[9:0]);
        end
        glob_ie = 1'b0;
        tick(2);
        check("int_gated", 0, int_pending);
        pend_write(64'h0);
        for (int c = 0; c < 18; c++) begin
            trap(1'b0, c[9:0], 2'h0, c == 10 || c == 14 || c >= 16);
        end
        for (int p = 0; p < 4; p++) begin
            rnd = $urandom;
            trap(1'b1, rnd[9:0], p[1:0], 1'b0);
        end
        // Software cause writes: legal pair lands, illegal pair is ignored whole
        cause_write(64'h8000_0000_0000_0003);
        check("cause_sw", 65'h8000_0000_0000_0003, cause_rdata);
        cause_write(64'h8000_0000_0000_000c);
        check("cause_sw_rsv", 65'h8000_0000_0000_0003, cause_rdata);
        cause_write(64'h7fff_ffff_ffff_fc0d);
        check("cause_sw_pad", 65'h0000_0000_0000_000d, cause_rdata);
        tick(3);
        check("notes_left", 0, exp_q.size());
        summarize();
    end
endmodule // mtpc_trap_test

// >>> verilog/mtpc_pkg.sv
// Shared constants for machine trap pending and cause bookkeeping
package mtpc_pkg;

    // Register and field widths
    localparam int XLEN = 64;
    localparam int CODE_W = 10;
    localparam int PEND_W = 12;

    // Bit positions in the pending status register
    localparam int POS_SUP_SOFT = 1;
    localparam int POS_MACH_SOFT = 3;
    localparam int POS_SUP_TIMER = 5;
    localparam int POS_MACH_TIMER = 7;
    localparam int POS_SUP_EXT = 9;
    localparam int POS_MACH_EXT = 11;

    // Interrupt flag position in the trap cause register
    localparam int POS_INT_FLAG = 63;

    // Software-writable pending bits (supervisor soft, timer, external)
    localparam logic [XLEN-1:0] PEND_SW_MASK = 64'h0000_0000_0000_0222;

    // Reset values
    localparam logic [PEND_W-1:0] PEND_RESET = 12'h000;
    localparam logic [CODE_W-1:0] CAUSE_CODE_RESET = 10'h000;
    localparam logic CAUSE_FLAG_RESET = 1'b0;

    // Synchronous exception codes
    localparam logic [CODE_W-1:0] EXC_INSTR_MISALIGN = 10'h000;
    localparam logic [CODE_W-1:0] EXC_INSTR_FAULT = 10'h001;
    localparam logic [CODE_W-1:0] EXC_ILLEGAL = 10'h002;
    localparam logic [CODE_W-1:0] EXC_BREAKPOINT = 10'h003;
    localparam logic [CODE_W-1:0] EXC_LOAD_MISALIGN = 10'h004;
    localparam logic [CODE_W-1:0] EXC_LOAD_FAULT = 10'h005;
    localparam logic [CODE_W-1:0] EXC_STORE_MISALIGN = 10'h006;
    localparam logic [CODE_W-1:0] EXC_STORE_FAULT = 10'h007;
    localparam logic [CODE_W-1:0] EXC_ECALL_USER = 10'h008;
    localparam logic [CODE_W-1:0] EXC_ECALL_SUP = 10'h009;
    localparam logic [CODE_W-1:0] EXC_ECALL_MACH = 10'h00b;
    localparam logic [CODE_W-1:0] EXC_INSTR_PAGE = 10'h00c;
    localparam logic [CODE_W-1:0] EXC_LOAD_PAGE = 10'h00d;
    localparam logic [CODE_W-1:0] EXC_STORE_PAGE = 10'h00f;

    // Privilege mode encoding of the hart
    localparam logic [1:0] PRIV_USER = 2'h0;
    localparam logic [1:0] PRIV_SUP = 2'h1;
    localparam logic [1:0] PRIV_MACH = 2'h3;

    // Input synchroniser depth
    localparam int SYNC_STAGES = 3;

    // Trap source chosen in a cycle, one-hot
    typedef enum logic [2:0] {
        TRAP_NONE = 3'b001,
        TRAP_EXC = 3'b010,
        TRAP_INT = 3'b100
    } mtpc_trap_t;

endpackage

// >>> verilog/mtpc_sync.sv
`timescale 1ns/1ns
// Three-stage level synchroniser with agreement filter
module mtpc_sync
    import mtpc_pkg::*;
#(
    parameter int STAGES = SYNC_STAGES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic din,
    output logic dout
);

    // Shift chain, stage 0 is read only by stage 1
    logic [STAGES-1:0] chain_r;
    logic [STAGES-1:0] chain_nxt;
    // Filtered level
    logic dout_r;
    logic dout_nxt;

    // Next values: shift, update output once the last two agree
    always_comb begin
        chain_nxt = {chain_r[STAGES-2:0], din};
        dout_nxt = dout_r;
        if (chain_r[STAGES-1] == chain_r[STAGES-2]) begin
            dout_nxt = chain_r[STAGES-1];
        end
    end

    // Registers only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            chain_r <= '0;
            dout_r <= 1'b0;
        end else begin
            chain_r <= chain_nxt;
            dout_r <= dout_nxt;
        end
    end

    assign dout = dout_r;

endmodule // mtpc_sync

// >>> verilog/mtpc_trap.sv
`timescale 1ns/1ns
// Functional notes
// - Pending register shows each awaiting interrupt
// - Bit 1 supervisor software pending, read/write
// - Bit 5 supervisor timer pending, read/write
// - Bit 9 supervisor external pending, read/write
// - Bit 3 machine software pending, read-only
// - Bit 7 machine timer pending, read-only
// - Bit 11 machine external pending, read-only
// - Unused pending bits ignore writes
// - Machine trap loads cause register
// - Interrupt trap sets top cause bit
// - Interrupt code equals pending bit position
// - Exception trap clears top cause bit
// - Ten-bit code field, legal values only
// - Bit 63 flags interrupt origin
// - Environment calls use codes 8, 9, 11; from privilege mode 2 they give code 2
// - Other exceptions use their listed codes
// - Interrupt needs global and individual enable
// - All external sources report code 11
module mtpc_trap
    import mtpc_pkg::*;
#(
    parameter int EXT_SRC = 4
) (
    input wire logic clk,
    input wire logic rstn,
    // Machine interrupt request levels from source logic
    input wire logic mach_soft_req,
    input wire logic mach_timer_req,
    input wire logic [EXT_SRC-1:0] mach_ext_req,
    // Enables kept elsewhere in the core
    input wire logic glob_ie,
    input wire logic [PEND_W-1:0] int_enable,
    // Interrupt offer to the pipeline
    output logic int_pending,
    output logic [CODE_W-1:0] int_code,
    input wire logic int_take,
    // Synchronous exception report from the pipeline
    input wire logic exc_valid,
    input wire logic [CODE_W-1:0] exc_code,
    input wire logic ecall_valid,
    input wire logic [1:0] priv_mode,
    output logic exc_reject,
    output logic trap_loaded,
    // Pending status register access
    input wire logic pend_we,
    input wire logic [XLEN-1:0] pend_wdata,
    output logic [XLEN-1:0] pend_rdata,
    // Trap cause register access
    input wire logic cause_we,
    input wire logic [XLEN-1:0] cause_wdata,
    output logic [XLEN-1:0] cause_rdata
);

    // Synchronised machine request levels
    logic msoft_s;
    logic mtimer_s;
    logic mext_s;
    // Raw lines before synchronising; externals are merged first
    logic [2:0] raw_req;
    logic [2:0] sync_req;

    // Supervisor pending bits, software owned
    logic sup_soft_pending_r;
    logic sup_soft_pending_nxt;
    logic sup_timer_pending_r;
    logic sup_timer_pending_nxt;
    logic sup_ext_pending_r;
    logic sup_ext_pending_nxt;

    // Pending image, low bits only
    logic [PEND_W-1:0] pend_vec;
    // Pending and enabled
    logic [PEND_W-1:0] armed_vec;

    // Registered interrupt offer
    logic int_pending_r;
    logic int_pending_nxt;
    logic [CODE_W-1:0] int_code_r;
    logic [CODE_W-1:0] int_code_nxt;

    // Trap cause storage
    logic cause_flag_r;
    logic cause_flag_nxt;
    logic [CODE_W-1:0] cause_code_r;
    logic [CODE_W-1:0] cause_code_nxt;

    // Strobes, registered
    logic exc_reject_r;
    logic exc_reject_nxt;
    logic trap_loaded_r;
    logic trap_loaded_nxt;

    // Trap arbitration
    mtpc_trap_t trap_sel;
    logic [CODE_W-1:0] exc_eff_code;
    logic exc_eff_valid;
    logic exc_eff_legal;
    logic sw_cause_legal;

    // Legal code test for the cause field
    function automatic logic code_legal(input logic flag, input logic [CODE_W-1:0] code);
        logic ok;
        ok = 1'b0;
        if (flag) begin
            // Only implemented interrupt numbers
            case (code)
                10'h001, 10'h003, 10'h005, 10'h007, 10'h009, 10'h00b: ok = 1'b1;
                default: ok = 1'b0;
            endcase
        end else begin
            // Codes 10, 14 and 16 upward are reserved
            case (code)
                EXC_INSTR_MISALIGN, EXC_INSTR_FAULT, EXC_ILLEGAL, EXC_BREAKPOINT,
                EXC_LOAD_MISALIGN, EXC_LOAD_FAULT, EXC_STORE_MISALIGN, EXC_STORE_FAULT,
                EXC_ECALL_USER, EXC_ECALL_SUP, EXC_ECALL_MACH, EXC_INSTR_PAGE,
                EXC_LOAD_PAGE, EXC_STORE_PAGE: ok = 1'b1;
                default: ok = 1'b0;
            endcase
        end
        return ok;
    endfunction

    // Merge all external sources into one line before crossing
    assign raw_req = {|mach_ext_req, mach_timer_req, mach_soft_req};

    // One synchroniser per machine request line
    // Merging before the crossing keeps one filter for the shared code;
    // a pulse shorter than two clocks may be lost, so sources hold levels
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            mtpc_sync #(
                .STAGES(SYNC_STAGES)
            ) u_sync (
                .clk(clk),
                .rstn(rstn),
                .din(raw_req[gi]),
                .dout(sync_req[gi])
            );
        end
    endgenerate

    // Machine flags follow the request levels, no latch of their own
    assign msoft_s = sync_req[0];
    assign mtimer_s = sync_req[1];
    assign mext_s = sync_req[2];

    // Supervisor pending next values; only software changes them
    always_comb begin
        sup_soft_pending_nxt = sup_soft_pending_r;
        sup_timer_pending_nxt = sup_timer_pending_r;
        sup_ext_pending_nxt = sup_ext_pending_r;
        if (pend_we) begin
            // Only masked positions take the write
            sup_soft_pending_nxt = pend_wdata[POS_SUP_SOFT];
            sup_timer_pending_nxt = pend_wdata[POS_SUP_TIMER];
            sup_ext_pending_nxt = pend_wdata[POS_SUP_EXT];
        end
    end

    // Pending image; machine bits ignore pend_wdata entirely
    always_comb begin
        pend_vec = '0;
        pend_vec[POS_SUP_SOFT] = sup_soft_pending_r;
        pend_vec[POS_SUP_TIMER] = sup_timer_pending_r;
        pend_vec[POS_SUP_EXT] = sup_ext_pending_r;
        pend_vec[POS_MACH_SOFT] = msoft_s;
        pend_vec[POS_MACH_TIMER] = mtimer_s;
        pend_vec[POS_MACH_EXT] = mext_s;
    end

    // Read view: reserved positions read as zero
    // Unused positions inside pend_vec are already tied low, so no mask
    // is needed here; software must not rely on them in any case
    assign pend_rdata = {{(XLEN-PEND_W){1'b0}}, pend_vec};

    // Gate by individual enables, then by the global enable
    assign armed_vec = pend_vec & int_enable & {PEND_W{glob_ie}};

    // Interrupt offer: fixed priority, machine before supervisor
    always_comb begin
        int_pending_nxt = |armed_vec;
        int_code_nxt = CAUSE_CODE_RESET;
        // Code is the bit position of the winning source
        if (armed_vec[POS_MACH_EXT]) begin
            int_code_nxt = CODE_W'(POS_MACH_EXT);
        end else if (armed_vec[POS_MACH_SOFT]) begin
            int_code_nxt = CODE_W'(POS_MACH_SOFT);
        end else if (armed_vec[POS_MACH_TIMER]) begin
            int_code_nxt = CODE_W'(POS_MACH_TIMER);
        end else if (armed_vec[POS_SUP_EXT]) begin
            int_code_nxt = CODE_W'(POS_SUP_EXT);
        end else if (armed_vec[POS_SUP_SOFT]) begin
            int_code_nxt = CODE_W'(POS_SUP_SOFT);
        end else if (armed_vec[POS_SUP_TIMER]) begin
            int_code_nxt = CODE_W'(POS_SUP_TIMER);
        end
    end

    // Environment calls map privilege to code; else pass pipeline code
    always_comb begin
        exc_eff_valid = exc_valid | ecall_valid;
        exc_eff_code = exc_code;
        if (ecall_valid) begin
            case (priv_mode)
                PRIV_USER: exc_eff_code = EXC_ECALL_USER;
                PRIV_SUP: exc_eff_code = EXC_ECALL_SUP;
                PRIV_MACH: exc_eff_code = EXC_ECALL_MACH;
                default: exc_eff_code = EXC_ILLEGAL;
            endcase
        end
    end

    // Reserved codes never reach the cause field
    assign exc_eff_legal = code_legal(1'b0, exc_eff_code);
    assign sw_cause_legal = code_legal(cause_wdata[POS_INT_FLAG], cause_wdata[CODE_W-1:0]);

    // Exception beats interrupt: it belongs to the current instruction
    // A take that meets an exception is dropped; the offer still stands
    // afterwards, so the pipeline simply takes it on a later cycle
    always_comb begin
        if (exc_eff_valid) begin
            trap_sel = TRAP_EXC;
        end else if (int_take && int_pending_r) begin
            // A take without an offer is ignored
            trap_sel = TRAP_INT;
        end else begin
            trap_sel = TRAP_NONE;
        end
    end

    // Cause next values; trap load wins over a software write
    always_comb begin
        cause_flag_nxt = cause_flag_r;
        cause_code_nxt = cause_code_r;
        exc_reject_nxt = 1'b0;
        trap_loaded_nxt = 1'b0;
        case (trap_sel)
            TRAP_EXC: begin
                if (exc_eff_legal) begin
                    cause_flag_nxt = 1'b0;
                    cause_code_nxt = exc_eff_code;
                    trap_loaded_nxt = 1'b1;
                end else begin
                    // Keep old cause, tell the pipeline
                    exc_reject_nxt = 1'b1;
                end
            end
            TRAP_INT: begin
                cause_flag_nxt = 1'b1;
                cause_code_nxt = int_code_r;
                trap_loaded_nxt = 1'b1;
            end
            TRAP_NONE: begin
                // Software write only with a legal pair
                if (cause_we && sw_cause_legal) begin
                    cause_flag_nxt = cause_wdata[POS_INT_FLAG];
                    cause_code_nxt = cause_wdata[CODE_W-1:0];
                end
            end
            default: begin
                cause_flag_nxt = cause_flag_r;
                cause_code_nxt = cause_code_r;
            end
        endcase
    end

    // Cause read view; bits 62..10 read zero
    assign cause_rdata = {cause_flag_r, {(XLEN-CODE_W-1){1'b0}}, cause_code_r};

    // State registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sup_soft_pending_r <= PEND_RESET[POS_SUP_SOFT];
            sup_timer_pending_r <= PEND_RESET[POS_SUP_TIMER];
            sup_ext_pending_r <= PEND_RESET[POS_SUP_EXT];
            int_pending_r <= 1'b0;
            int_code_r <= CAUSE_CODE_RESET;
            cause_flag_r <= CAUSE_FLAG_RESET;
            cause_code_r <= CAUSE_CODE_RESET;
            exc_reject_r <= 1'b0;
            trap_loaded_r <= 1'b0;
        end else begin
            sup_soft_pending_r <= sup_soft_pending_nxt;
            sup_timer_pending_r <= sup_timer_pending_nxt;
            sup_ext_pending_r <= sup_ext_pending_nxt;
            int_pending_r <= int_pending_nxt;
            int_code_r <= int_code_nxt;
            cause_flag_r <= cause_flag_nxt;
            cause_code_r <= cause_code_nxt;
            exc_reject_r <= exc_reject_nxt;
            trap_loaded_r <= trap_loaded_nxt;
        end
    end

    // Outputs straight from flops
    assign int_pending = int_pending_r;
    assign int_code = int_code_r;
    assign exc_reject = exc_reject_r;
    assign trap_loaded = trap_loaded_r;

endmodule // mtpc_trap
